// File: hw/asrao_top.sv
// Purpose: Sample rate timer, per-slot summing/averaging and offset subtraction
// Assumes: SPI-style serial port, serial clock well below clk/8; ADC results
//   arrive from same-clock logic with a slot bit and a channel number
// Notes: Frame is 7 address bits, a write bit, 16 data bits
`timescale 1ns/10ps
module asrao_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic lf_clk_32k,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  output logic sample_tick,
  input wire logic adc_valid,
  output logic adc_ready,
  input wire logic adc_slot,
  input wire logic [1:0] adc_ch,
  input wire logic [15:0] adc_raw
);
  typedef enum logic [1:0] {
    ASRAO_IDLE = 2'b00,
    ASRAO_HDR = 2'b01,
    ASRAO_DATA = 2'b10
  } asrao_spi_t;

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] csn_s;
    logic [1:0] mosi_s;
    logic [1:0] lf_s;
    logic sclk_d;
    logic lf_d;
    asrao_spi_t spi;
    logic [4:0] bitcnt;
    logic [6:0] addr;
    logic wr;
    logic [15:0] shin;
    logic [15:0] shout;
    logic miso;
    logic [15:0] div;
    logic [15:0] avgcfg;
    logic [7:0][15:0] ofs;
    logic [17:0] lfcnt;
    logic tick;
    logic [1:0][6:0] nsmp;
    logic [7:0][asrao_pkg::SUM_W-1:0] acc;
    logic [7:0][asrao_pkg::SUM_W-1:0] sum;
    logic [7:0][15:0] avg;
  } asrao_state_t;

  logic [1:0] rst_q;
  logic rst_n;
  asrao_state_t s_r;
  asrao_state_t s_nxt;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [15:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [15:0] fifo_out_data;

  // Offset register decode: hit flag, slot bit, channel
  function automatic logic [3:0] ofs_index(input logic [6:0] a);
    logic [6:0] d;
    d = 7'(a - asrao_pkg::REG_OFS_SECOND_BASE);
    if (a[6:2] == asrao_pkg::REG_OFS_FIRST_BASE[6:2]) begin
      ofs_index = {2'b10, a[1:0]};
    end else if (a >= asrao_pkg::REG_OFS_SECOND_BASE && d < 7'h04) begin
      ofs_index = {2'b11, d[1:0]};
    end else begin
      ofs_index = 4'h0;
    end
  endfunction

  function automatic logic [15:0] rd_word(input asrao_state_t s, input logic [6:0] a,
                                          input logic fv, input logic [15:0] fd);
    logic [3:0] oi;
    logic [6:0] si;
    logic [6:0] vi;
    oi = ofs_index(a);
    si = 7'(a - asrao_pkg::REG_SUM_BASE);
    vi = 7'(a - asrao_pkg::REG_AVG_BASE);
    rd_word = 16'h0000;
    if (a == asrao_pkg::REG_SAMPLE_RATE_DIVIDER) begin
      rd_word = s.div;
    end else if (a == asrao_pkg::REG_SLOT_AVERAGING_CONFIG) begin
      rd_word = s.avgcfg;
    end else if (oi[3]) begin
      rd_word = s.ofs[oi[2:0]];
    end else if (a == asrao_pkg::REG_FIFO_DATA) begin
      rd_word = fv ? fd : 16'h0000;
    end else if (a >= asrao_pkg::REG_AVG_BASE && vi < 7'h08) begin
      rd_word = s.avg[vi[2:0]];
    end else if (a >= asrao_pkg::REG_SUM_BASE && a <= asrao_pkg::REG_SUM_LAST) begin
      // Low words then high words, per slot
      if (si[2]) begin
        rd_word = 16'(s.sum[{si[3], si[1:0]}][asrao_pkg::SUM_W-1:16]);
      end else begin
        rd_word = s.sum[{si[3], si[1:0]}][15:0];
      end
    end
  endfunction

  // Reset is released through two flops so every state flop leaves reset together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  logic take;
  logic [2:0] idx;
  logic [2:0] code;
  logic [6:0] nmax;
  logic done;
  logic [15:0] diff;
  logic [asrao_pkg::SUM_W-1:0] newsum;
  logic [15:0] newavg;

  always_comb begin
    take = adc_valid & adc_ready;
    idx = {adc_slot, adc_ch};
    code = adc_slot
      ? s_r.avgcfg[asrao_pkg::SECOND_SLOT_AVG_LSB +: asrao_pkg::AVG_CODE_W]
      : s_r.avgcfg[asrao_pkg::FIRST_SLOT_AVG_LSB +: asrao_pkg::AVG_CODE_W];
    nmax = 7'((8'h01 << code) - 8'h01);
    // Negative results clamp at zero rather than wrapping into a huge sum
    diff = (adc_raw > s_r.ofs[idx]) ? 16'(adc_raw - s_r.ofs[idx]) : 16'h0000;
    newsum = asrao_pkg::SUM_W'(s_r.acc[idx] + asrao_pkg::SUM_W'(diff));
    newavg = 16'(newsum >> code);
    // >= so that lowering N mid-run finishes the pending block at once
    done = (s_r.nsmp[adc_slot] >= nmax);
    fifo_in_valid = take & done;
    fifo_in_data = newavg;
  end

  always_comb begin
    logic [15:0] shin_nxt;
    logic [3:0] oi;
    logic rise;
    logic fall;
    shin_nxt = {s_r.shin[14:0], s_r.mosi_s[1]};
    oi = ofs_index(s_r.addr);
    rise = s_r.sclk_s[1] & ~s_r.sclk_d;
    fall = ~s_r.sclk_s[1] & s_r.sclk_d;
    s_nxt = s_r;
    fifo_out_ready = 1'b0;
    s_nxt.sclk_s = {s_r.sclk_s[0], spi_sclk};
    s_nxt.csn_s = {s_r.csn_s[0], spi_csn};
    s_nxt.mosi_s = {s_r.mosi_s[0], spi_mosi};
    s_nxt.lf_s = {s_r.lf_s[0], lf_clk_32k};
    s_nxt.sclk_d = s_r.sclk_s[1];
    s_nxt.lf_d = s_r.lf_s[1];
    s_nxt.tick = 1'b0;

    if (s_r.lf_s[1] & ~s_r.lf_d) begin
      if (18'(s_r.lfcnt + 18'd1) >= {s_r.div, 2'b00}) begin
        s_nxt.lfcnt = '0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.lfcnt = 18'(s_r.lfcnt + 18'd1);
      end
    end

    if (s_r.csn_s[1]) begin
      s_nxt.spi = ASRAO_IDLE;
      s_nxt.bitcnt = '0;
    end else begin
      case (s_r.spi)
        ASRAO_IDLE: begin
          s_nxt.spi = ASRAO_HDR;
        end
        ASRAO_HDR: begin
          if (rise) begin
            s_nxt.shin = shin_nxt;
            s_nxt.bitcnt = 5'(s_r.bitcnt + 5'd1);
            if (s_r.bitcnt == asrao_pkg::SPI_HDR_LAST) begin
              s_nxt.addr = shin_nxt[7:1];
              s_nxt.wr = shin_nxt[0];
              s_nxt.spi = ASRAO_DATA;
              if (!shin_nxt[0]) begin
                s_nxt.shout = rd_word(s_r, shin_nxt[7:1], fifo_out_valid, fifo_out_data);
                // Reading the buffer word consumes it
                fifo_out_ready = (shin_nxt[7:1] == asrao_pkg::REG_FIFO_DATA);
              end
            end
          end
        end
        ASRAO_DATA: begin
          if (rise && s_r.bitcnt <= asrao_pkg::SPI_FRAME_LAST) begin
            s_nxt.shin = shin_nxt;
            s_nxt.bitcnt = 5'(s_r.bitcnt + 5'd1);
            if (s_r.bitcnt == asrao_pkg::SPI_FRAME_LAST && s_r.wr) begin
              if (s_r.addr == asrao_pkg::REG_SAMPLE_RATE_DIVIDER) begin
                s_nxt.div = shin_nxt;
              end else if (s_r.addr == asrao_pkg::REG_SLOT_AVERAGING_CONFIG) begin
                s_nxt.avgcfg = shin_nxt & asrao_pkg::AVG_CFG_MASK;
              end else if (oi[3]) begin
                s_nxt.ofs[oi[2:0]] = shin_nxt;
              end
            end
          end
          if (fall && !s_r.wr) begin
            s_nxt.miso = s_r.shout[15];
            s_nxt.shout = {s_r.shout[14:0], 1'b0};
          end
        end
        default: begin
          s_nxt.spi = ASRAO_IDLE;
        end
      endcase
    end

    if (take) begin
      if (done) begin
        s_nxt.sum[idx] = newsum;
        s_nxt.avg[idx] = newavg;
        s_nxt.acc[idx] = '0;
      end else begin
        s_nxt.acc[idx] = newsum;
      end
      // Block count advances once the last channel of the slot is in
      if (adc_ch == 2'(asrao_pkg::CH_PER_SLOT - 1)) begin
        s_nxt.nsmp[adc_slot] = done ? 7'h00 : 7'(s_r.nsmp[adc_slot] + 7'h01);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.csn_s <= 2'b11;
      s_r.spi <= ASRAO_IDLE;
      s_r.div <= asrao_pkg::SAMPLE_RATE_DIVIDER_RST;
      s_r.avgcfg <= 16'h0000
        | (16'(asrao_pkg::SECOND_SLOT_AVG_RST) << asrao_pkg::SECOND_SLOT_AVG_LSB)
        | (16'(asrao_pkg::FIRST_SLOT_AVG_RST) << asrao_pkg::FIRST_SLOT_AVG_LSB);
      s_r.ofs <= {8{asrao_pkg::ADC_OFFSET_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  asrao_fifo #(
    .WIDTH(asrao_pkg::DATA_W),
    .DEPTH(asrao_pkg::FIFO_DEPTH)
  ) i_asrao_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Full buffer stalls the ADC source rather than dropping averages
  assign adc_ready = fifo_in_ready;
  assign sample_tick = s_r.tick;
  assign spi_miso_o = s_r.miso;
  assign spi_miso_oe = (s_r.spi == ASRAO_DATA) & ~s_r.wr & ~s_r.csn_s[1];
endmodule // asrao_top

// File: hw/asrao_pkg.sv
// Purpose: Shared constants for the ADC sample rate, averaging and offset block
// Assumes: 7-bit register addresses, 16-bit register data
// Notes: Register offsets are the printed word addresses of the serial port
package asrao_pkg;
  // Register map
  localparam logic [6:0] REG_SAMPLE_RATE_DIVIDER = 7'h12;
  localparam logic [6:0] REG_SLOT_AVERAGING_CONFIG = 7'h15;
  localparam logic [6:0] REG_OFS_FIRST_BASE = 7'h18;
  localparam logic [6:0] REG_OFS_SECOND_BASE = 7'h1E;
  localparam logic [6:0] REG_FIFO_DATA = 7'h60;
  localparam logic [6:0] REG_AVG_BASE = 7'h64;
  localparam logic [6:0] REG_SUM_BASE = 7'h70;
  localparam logic [6:0] REG_SUM_LAST = 7'h7F;
  // Reset values and fields
  localparam logic [15:0] SAMPLE_RATE_DIVIDER_RST = 16'h0028;
  localparam logic [2:0] SECOND_SLOT_AVG_RST = 3'h6;
  localparam logic [2:0] FIRST_SLOT_AVG_RST = 3'h0;
  localparam logic [15:0] ADC_OFFSET_RST = 16'h2000;
  localparam int SECOND_SLOT_AVG_LSB = 8;
  localparam int FIRST_SLOT_AVG_LSB = 4;
  localparam int AVG_CODE_W = 3;
  localparam logic [15:0] AVG_CFG_MASK = 16'h0770;
  // Sample timing: one sample per divider times this many low-rate rising edges; divider 0 gives one per rising edge
  localparam int LF_CLK_KHZ = 32;
  localparam int LF_EDGES_PER_UNIT = 4;
  // Data path
  localparam int DATA_W = 16;
  localparam int SUM_W = 24;
  localparam int FIFO_DEPTH = 8;
  localparam int CH_PER_SLOT = 4;
  // Serial frame: 7 address bits, 1 write bit, 16 data bits
  localparam logic [4:0] SPI_HDR_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
endpackage

// File: hw/asrao_fifo.sv
// Purpose: Small synchronous FIFO between the averager and the data register
// Assumes: Single clock, active-low reset copy released by the parent
// Notes: Read data is shown while out_valid is high; a pop is out_valid and out_ready
`timescale 1ns/10ps
module asrao_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } asrao_fifo_state_t;

  asrao_fifo_state_t s_r;
  asrao_fifo_state_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : AW'(s_r.wp + 1'b1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : AW'(s_r.rp + 1'b1);
    end
    case ({push, pop})
      2'b10: s_nxt.cnt = (AW+1)'(s_r.cnt + 1'b1);
      2'b01: s_nxt.cnt = (AW+1)'(s_r.cnt - 1'b1);
      default: s_nxt.cnt = s_r.cnt;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // asrao_fifo

// File: test/asrao_assertions.sv
// Purpose: Port-level checks for asrao_top
// Assumes: One clock, resetn async active low
// Notes: Tick gap bound assumes a 32 kHz low-rate clock
`timescale 1ns/10ps
module asrao_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic lf_clk_32k,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe,
  input wire logic sample_tick,
  input wire logic adc_valid,
  input wire logic adc_ready,
  input wire logic adc_slot,
  input wire logic [1:0] adc_ch,
  input wire logic [15:0] adc_raw
);
  int gap_r;
  logic seen_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= sample_tick ? 0 : gap_r + 1;
      seen_r <= seen_r | sample_tick;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_TICK_PULSE: assert property (sample_tick |=> !sample_tick)
    else $error("tick longer than one cycle");
  AST_TICK_LF: assert property (sample_tick |-> $past(lf_clk_32k, 2))
    else $error("tick without low-rate edge");
  AST_TICK_GAP: assert property (sample_tick && seen_r |-> gap_r >= 700)
    else $error("ticks closer than one low-rate period");
  AST_OE_IDLE: assert property (spi_csn [*6] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  AST_OE_DROP: assert property ($rose(spi_csn) |-> ##[1:5] !spi_miso_oe)
    else $error("miso not released after frame");
  AST_READY_FALL: assert property ($fell(adc_ready) |-> $past(adc_valid) || $past(adc_valid, 2))
    else $error("buffer filled without a sample");
  AST_READY_RISE: assert property ($rose(adc_ready) |-> !$past(spi_csn, 2))
    else $error("buffer drained without a read");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    !resetn |-> adc_ready && !sample_tick && !spi_miso_oe)
    else $error("outputs active in reset");
  cover property (sample_tick);
  cover property (!adc_ready);
  cover property (spi_miso_oe);
endmodule // asrao_checker

// File: test/asrao_host.sv
// Purpose: Host model driving the serial register port
// Assumes: Mode 0, sclk half period of 5 clk
// Notes: An undriven miso reads as 1, like a pulled-up line
`timescale 1ns/10ps
module asrao_host (
  input wire logic clk,
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_mosi,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe
);
  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [6:0] a, input logic w, input logic [15:0] d,
                      output logic [15:0] q);
    logic [23:0] f;
    f = {a, w, d};
    q = 16'h0000;
    spi_csn = 1'b0;
    for (int i = 0; i < 24; i++) begin
      spi_mosi = f[23-i];
      hold(5);
      if (i >= 8)
        q = {q[14:0], spi_miso_oe ? spi_miso_o : 1'b1};
      spi_sclk = 1'b1;
      hold(5);
      spi_sclk = 1'b0;
    end
    hold(5);
    spi_csn = 1'b1;
    hold(6);
  endtask
endmodule // asrao_host

// File: test/test_adc_sample_rate_average_offset.sv
// Purpose: Self-checking bench for asrao_top
// Assumes: Host model on serial port, bench as ADC source
// Notes: Low-rate clock runs at 32 kHz, unrelated to clk
`timescale 1ns/10ps
module test_adc_sample_rate_average_offset;
  logic clk, resetn, lf_clk_32k, spi_sclk, spi_csn, spi_mosi, spi_miso_o, spi_miso_oe;
  logic sample_tick, adc_valid, adc_ready, adc_slot;
  logic [1:0] adc_ch;
  logic [15:0] adc_raw, q;
  int num_errors = 0;
  int n_tests = 0;
  int n;
  asrao_top i_asrao_top (.clk(clk), .resetn(resetn), .lf_clk_32k(lf_clk_32k),
    .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
    .spi_miso_oe(spi_miso_oe), .sample_tick(sample_tick), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .adc_slot(adc_slot), .adc_ch(adc_ch), .adc_raw(adc_raw));
  asrao_host i_asrao_host (.clk(clk), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lf_clk_32k = 1'b0;
    forever #15625 lf_clk_32k = ~lf_clk_32k;
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_asrao_host.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    i_asrao_host.xfer(a, 1'b0, 16'h0000, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic put(input logic s, input logic [1:0] c, input logic [15:0] r);
    int k;
    adc_slot = s;
    adc_ch = c;
    adc_raw = r;
    adc_valid = 1'b1;
    for (k = 0; k < 200 && adc_ready !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) begin
      num_errors++;
      $display("[FAIL] adc_ready expected 1 seen %b", adc_ready);
    end
    @(posedge clk);
    #1 adc_valid = 1'b0;
    // One idle edge so valid never toggles within a time step
    @(posedge clk);
    #1;
  endtask
  // Cycles between two ticks; the first tick only aligns
  task automatic tick_gap(output int m);
    repeat (2) begin
      m = 0;
      do begin
        @(posedge clk);
        #1;
        m++;
      end while (sample_tick !== 1'b1 && m < 8000);
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    // Start high so the fall at 1 ns is a clean asynchronous edge
    resetn = 1'b1;
    adc_valid = 1'b0;
    adc_slot = 1'b0;
    adc_ch = 2'h0;
    adc_raw = 16'h0000;
    #1 resetn = 1'b0;
    repeat (4) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rd(7'h12, 16'h0028);
    rd(7'h15, 16'h0600);
    rd(7'h18, 16'h2000);
    rd(7'h05, 16'h0000);
    $display("Test reset values done");
    wr(7'h12, 16'h0001);
    tick_gap(n);
    chk("gap div 1", 16'h0001, {15'h0000, n > 3117 && n < 3133});
    wr(7'h12, 16'h0000);
    tick_gap(n);
    chk("gap div 0", 16'h0001, {15'h0000, n > 774 && n < 789});
    $display("Test sample rate done");
    for (int k = 0; k < 8; k++) begin
      wr(7'h15, {5'h1F, 3'(k), 1'b1, 3'(7 - k), 4'hF});
      rd(7'h15, {5'h00, 3'(k), 1'b0, 3'(7 - k), 4'h0});
    end
    $display("Test averaging codes done");
    wr(7'h15, 16'h0000);
    wr(7'h18, 16'h0100);
    for (int i = 0; i < 8; i++)
      put(1'b0, 2'h0, 16'(16'h0100 + 3 * i));
    chk("ready when full", 16'h0000, {15'h0000, adc_ready});
    rd(7'h64, 16'h0015);
    rd(7'h70, 16'h0015);
    rd(7'h74, 16'h0000);
    for (int i = 0; i < 8; i++)
      rd(7'h60, 16'(3 * i));
    rd(7'h60, 16'h0000);
    chk("ready when empty", 16'h0001, {15'h0000, adc_ready});
    $display("Test buffer and offset done");
    wr(7'h15, 16'h0200);
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++)
        put(1'b1, 2'(c), 16'(16'h2000 + p + c + 1));
      if (p == 2)
        rd(7'h60, 16'h0000);
    end
    for (int c = 0; c < 4; c++)
      rd(7'h60, 16'(2 + c));
    rd(7'h68, 16'h0002);
    rd(7'h78, 16'h000A);
    rd(7'h7B, 16'h0016);
    rd(7'h7C, 16'h0000);
    $display("Test slot averaging done");
    print_verdict();
  end
endmodule // test_adc_sample_rate_average_offset
bind asrao_top asrao_checker i_chk (.clk(clk), .resetn(resetn), .lf_clk_32k(lf_clk_32k),
  .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
  .spi_miso_oe(spi_miso_oe), .sample_tick(sample_tick), .adc_valid(adc_valid),
  .adc_ready(adc_ready), .adc_slot(adc_slot), .adc_ch(adc_ch), .adc_raw(adc_raw));
